// ===== verilog/cgd_map.svh
`ifndef CGD_MAP_SVH
`define CGD_MAP_SVH

// Register offsets on the plain port
`define CGD_ADDR_TRIM 8'h00
`define CGD_ADDR_DIV 8'h01
`define CGD_ADDR_AUX1 8'h02
`define CGD_ADDR_STAT 8'h03

// Field positions
`define CGD_TRIM_RC_OSC_CLOCK_BIT 7
`define CGD_TRIM_CLOCK_OUT_ENABLE_BIT 6
`define CGD_AUX1_LP_BIT 7
`define CGD_STAT_RUN_BIT 7
`define CGD_STAT_AVAIL_BIT 6
`define CGD_STAT_DRIVE_BIT 5

// Reset values
`define CGD_DIV_RST 8'h00
`define CGD_LP_RST 1'h0
`define CGD_CLOCK_OUT_ENABLE_POR 1'h0
`define CGD_RC_OSC_CLOCK_POR 1'h0

// Oscillator source codes held in configuration
`define CGD_SRC_XTAL_LOW 3'h0
`define CGD_SRC_XTAL_MED 3'h1
`define CGD_SRC_XTAL_HIGH 3'h2
`define CGD_SRC_RC 3'h3
`define CGD_SRC_WDT 3'h4
`define CGD_SRC_EXT 3'h5

// Wake-up delay
`define CGD_XTAL_ROOT_CYC 10'h3e0
`define CGD_OTHER_ROOT_CYC 10'h0e0
`define CGD_WAKE_US_MIN 60
`define CGD_CLK_MHZ 10

`endif

// ===== verilog/cgd_pkg.sv
`default_nettype none
`include "cgd_map.svh"

package cgd_pkg;

  typedef enum logic [1:0] {CGD_WK_ROOT, CGD_WK_US, CGD_WK_DONE} cgd_wake_st_t;

  typedef struct packed {
    cgd_wake_st_t st;
    logic [9:0] cnt;
  } cgd_wake_state_t;

  typedef struct packed {
    logic [2:0] cfg;
    logic [5:0] trim;
    logic rc_osc_clock;
    logic clkout_en;
    logic [7:0] div_reg;
    logic [7:0] div_act;
    logic [7:0] div_cnt;
    logic lp;
    logic root_q;
    logic running;
    logic cpu_clk;
    logic per_clk;
    logic mc_phase;
    logic mc_start;
    logic drive;
    logic pin_o;
    logic pin_oe_n;
    logic port_in;
    logic [7:0] rdata;
  } cgd_state_t;

  function automatic logic cgd_is_crystal(input logic [2:0] src);
    cgd_is_crystal = (src == `CGD_SRC_XTAL_LOW) || (src == `CGD_SRC_XTAL_MED) || (src == `CGD_SRC_XTAL_HIGH);
  endfunction : cgd_is_crystal

  function automatic logic cgd_root_level(input logic [2:0] src, input logic wdt, input logic rc,
                                          input logic xtal, input logic ext);
    case (src)
      `CGD_SRC_RC: cgd_root_level = rc;
      `CGD_SRC_WDT: cgd_root_level = wdt;
      `CGD_SRC_EXT: cgd_root_level = ext;
      default: cgd_root_level = xtal;
    endcase
  endfunction : cgd_root_level

endpackage : cgd_pkg

`default_nettype wire

// ===== verilog/cgd_wake_timer.sv
`default_nettype none
`include "cgd_map.svh"

module cgd_wake_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic restart,
  input wire logic root_tick,
  input wire logic crystal,
  // Status
  output logic done
);

  localparam logic [9:0] US_CYC = 10'(`CGD_WAKE_US_MIN * `CGD_CLK_MHZ);

  cgd_pkg::cgd_wake_state_t s_reg;
  cgd_pkg::cgd_wake_state_t s_next;
  logic [9:0] limit;

  assign limit = crystal ? `CGD_XTAL_ROOT_CYC : `CGD_OTHER_ROOT_CYC;

  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      cgd_pkg::CGD_WK_ROOT: begin
        if (root_tick) begin
          if (s_reg.cnt == limit - 10'h001) begin
            s_next.st = cgd_pkg::CGD_WK_US;
            s_next.cnt = 10'h000;
          end else begin
            s_next.cnt = s_reg.cnt + 10'h001;
          end
        end
      end
      cgd_pkg::CGD_WK_US: begin
        if (s_reg.cnt == US_CYC - 10'h001) begin
          s_next.st = cgd_pkg::CGD_WK_DONE;
          s_next.cnt = 10'h000;
        end else begin
          s_next.cnt = s_reg.cnt + 10'h001;
        end
      end
      cgd_pkg::CGD_WK_DONE: begin
        s_next.cnt = 10'h000;
      end
      default: begin
        s_next.st = cgd_pkg::CGD_WK_ROOT;
        s_next.cnt = 10'h000;
      end
    endcase
    if (rst || restart) begin
      s_next.st = cgd_pkg::CGD_WK_ROOT;
      s_next.cnt = 10'h000;
    end
  end

  always_ff @(posedge sys_clk) begin
    s_reg <= s_next;
  end

  assign done = (s_reg.st == cgd_pkg::CGD_WK_DONE);

  us_span_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(s_reg.st == cgd_pkg::CGD_WK_US) && !restart |-> !done [*8])
    else $error("wake delay ended early");
  restart_clears_a: assert property (@(posedge sys_clk) disable iff (rst)
    restart |=> !done) else $error("restart did not hold clock");

endmodule : cgd_wake_timer

`default_nettype wire

// ===== verilog/cgd_clock_gen.sv
// How it works
// - A machine cycle is two CPU clock cycles; a start pulse marks each.
// - Peripheral clock toggles on each CPU clock rise, giving half rate.
// - Root clock is chosen from watchdog, RC, crystal or external source.
// - Source choice comes from configuration captured at reset, not software.
// - Clock output only when neither main clock nor RTC uses the crystal.
// - Clock output is driven onto the pin only while the enable bit is set.
// - Clock output runs at half the CPU clock rate.
// - Six-bit trim field loads factory value at power-on reset, writable by software.
// - Trim loads only on power-on reset; other resets keep it.
// - With non-crystal source the pin serves the port or clock output.
// - Crystal sources hold CPU clock 992 root cycles plus fixed interval.
// - Other sources hold CPU clock 224 root cycles plus fixed interval.
// - CPU clock is root clock divided by a programmable factor up to 510.
// - A new divider value is accepted any time without stopping execution.
// - Low-power bit clears on every reset; software sets it when slow enough.
`default_nettype none
`include "cgd_map.svh"

module cgd_clock_gen (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic por_reset,
  // Configuration and factory values
  input wire logic [2:0] cfg_osc_sel,
  input wire logic [5:0] factory_trim,
  input wire logic rtc_uses_crystal,
  // Oscillator levels
  input wire logic wdt_osc_level,
  input wire logic rc_osc_level,
  input wire logic xtal_osc_level,
  input wire logic ext_clk_level,
  // Wake from power-down
  input wire logic wake_request,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Crystal output / clock output pin
  input wire logic crystal_out_clock_out_pin_i,
  output logic crystal_out_clock_out_pin_o,
  output logic crystal_out_clock_out_pin_oe_n,
  // Port function of that pin
  input wire logic port_out_data,
  input wire logic port_out_oe_n,
  output logic port_in_data,
  // Clocks and status
  output logic osc_root_clock,
  output logic cpu_core_clock,
  output logic periph_clock,
  output logic machine_cycle_start,
  output logic cpu_clock_running,
  output logic [5:0] rc_osc_trim,
  output logic rc_osc_clock_select,
  output logic low_power_clock_select
);

  cgd_pkg::cgd_state_t s_reg;
  cgd_pkg::cgd_state_t s_next;
  logic root_now;
  logic root_tick;
  logic cpu_rise;
  logic avail;
  logic port_mode;
  logic wake_done;

  assign root_now = cgd_pkg::cgd_root_level(s_reg.cfg, wdt_osc_level, rc_osc_level,
                                            xtal_osc_level, ext_clk_level);
  assign root_tick = root_now & ~s_reg.root_q;

  assign avail = !cgd_pkg::cgd_is_crystal(s_reg.cfg) && !rtc_uses_crystal;
  assign port_mode = !cgd_pkg::cgd_is_crystal(s_reg.cfg);

  cgd_wake_timer u_wake (
    .sys_clk(sys_clk),
    .rst(rst),
    .restart(wake_request),
    .root_tick(root_tick),
    .crystal(cgd_pkg::cgd_is_crystal(s_reg.cfg)),
    .done(wake_done)
  );

  always_comb begin
    s_next = s_reg;
    s_next.mc_start = 1'b0;
    s_next.rdata = 8'h00;
    s_next.root_q = root_now;
    s_next.running = wake_done && !wake_request;
    s_next.port_in = crystal_out_clock_out_pin_i;

    if (!s_reg.running) begin
      s_next.cpu_clk = 1'b0;
      s_next.div_cnt = 8'h00;
    end else if (s_reg.div_act == 8'h00) begin
      s_next.cpu_clk = root_now;
    end else if (root_tick) begin
      if (s_reg.div_cnt == s_reg.div_act - 8'h01) begin
        s_next.div_cnt = 8'h00;
        s_next.cpu_clk = ~s_reg.cpu_clk;
      end else begin
        s_next.div_cnt = s_reg.div_cnt + 8'h01;
      end
    end

    cpu_rise = s_next.cpu_clk & ~s_reg.cpu_clk;
    if (cpu_rise) begin
      s_next.div_act = s_reg.div_reg;
      s_next.div_cnt = 8'h00;
      s_next.per_clk = ~s_reg.per_clk;
      s_next.mc_phase = ~s_reg.mc_phase;
      s_next.mc_start = ~s_reg.mc_phase;
    end

    s_next.drive = avail && s_reg.clkout_en;
    if (s_next.drive) begin
      s_next.pin_o = s_next.per_clk;
      s_next.pin_oe_n = 1'b0;
    end else if (port_mode) begin
      s_next.pin_o = port_out_data;
      s_next.pin_oe_n = port_out_oe_n;
    end else begin
      // Crystal owns the pin
      s_next.pin_o = 1'b0;
      s_next.pin_oe_n = 1'b1;
    end

    if (reg_wr) begin
      case (reg_addr)
        `CGD_ADDR_TRIM: begin
          s_next.trim = reg_wdata[5:0];
          s_next.clkout_en = reg_wdata[`CGD_TRIM_CLOCK_OUT_ENABLE_BIT];
          s_next.rc_osc_clock = reg_wdata[`CGD_TRIM_RC_OSC_CLOCK_BIT];
        end
        `CGD_ADDR_DIV: s_next.div_reg = reg_wdata;
        `CGD_ADDR_AUX1: s_next.lp = reg_wdata[`CGD_AUX1_LP_BIT];
        default: ;
      endcase
    end

    if (reg_rd) begin
      case (reg_addr)
        `CGD_ADDR_TRIM: s_next.rdata = {s_reg.rc_osc_clock, s_reg.clkout_en, s_reg.trim};
        `CGD_ADDR_DIV: s_next.rdata = s_reg.div_reg;
        `CGD_ADDR_AUX1: s_next.rdata = {s_reg.lp, 7'h00};
        `CGD_ADDR_STAT: begin
          s_next.rdata = {5'h00, s_reg.cfg};
          s_next.rdata[`CGD_STAT_RUN_BIT] = s_reg.running;
          s_next.rdata[`CGD_STAT_AVAIL_BIT] = avail;
          s_next.rdata[`CGD_STAT_DRIVE_BIT] = s_reg.drive;
        end
        default: s_next.rdata = 8'h00;
      endcase
    end

    if (rst) begin
      s_next = '0;
      s_next.cfg = cfg_osc_sel;
      s_next.trim = por_reset ? factory_trim : s_reg.trim;
      s_next.clkout_en = por_reset ? `CGD_CLOCK_OUT_ENABLE_POR : s_reg.clkout_en;
      s_next.rc_osc_clock = por_reset ? `CGD_RC_OSC_CLOCK_POR : s_reg.rc_osc_clock;
      s_next.lp = `CGD_LP_RST;
      s_next.div_reg = `CGD_DIV_RST;
      s_next.div_act = `CGD_DIV_RST;
      s_next.pin_oe_n = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    s_reg <= s_next;
  end

  assign reg_rdata = s_reg.rdata;
  assign crystal_out_clock_out_pin_o = s_reg.pin_o;
  assign crystal_out_clock_out_pin_oe_n = s_reg.pin_oe_n;
  assign port_in_data = s_reg.port_in;
  assign osc_root_clock = s_reg.root_q;
  assign cpu_core_clock = s_reg.cpu_clk;
  assign periph_clock = s_reg.per_clk;
  assign machine_cycle_start = s_reg.mc_start;
  assign cpu_clock_running = s_reg.running;
  assign rc_osc_trim = s_reg.trim;
  assign rc_osc_clock_select = s_reg.rc_osc_clock;
  assign low_power_clock_select = s_reg.lp;

  default clocking cgd_cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  mc_two_clocks_a: assert property (
    s_reg.mc_start |-> $rose(s_reg.cpu_clk) && s_reg.mc_phase)
    else $error("machine cycle start not on every second clock");
  per_half_a: assert property (
    $changed(s_reg.per_clk) |-> $rose(s_reg.cpu_clk))
    else $error("peripheral clock moved off a CPU clock rise");
  cfg_hold_a: assert property (
    1'b1 |=> $stable(s_reg.cfg))
    else $error("source changed outside reset");
  pin_avail_a: assert property (
    !s_reg.pin_oe_n && s_reg.drive |-> !cgd_pkg::cgd_is_crystal(s_reg.cfg) && !$past(rtc_uses_crystal))
    else $error("clock output driven while crystal in use");
  enable_gate_a: assert property (
    s_reg.drive |-> $past(s_reg.clkout_en))
    else $error("clock output driven without enable");
  clkout_rate_a: assert property (
    s_reg.drive |-> s_reg.pin_o == s_reg.per_clk)
    else $error("clock output not at half CPU rate");
  trim_load_a: assert property (disable iff (1'b0)
    rst && por_reset |=> s_reg.trim == $past(factory_trim))
    else $error("factory trim not loaded");
  trim_keep_a: assert property (disable iff (1'b0)
    rst && !por_reset |=> s_reg.trim == $past(s_reg.trim))
    else $error("trim changed by a warm reset");
  lp_clear_a: assert property (disable iff (1'b0)
    rst |=> !s_reg.lp)
    else $error("low power bit not cleared by reset");
  held_low_a: assert property (
    !wake_done ##1 !wake_done |=> !s_reg.cpu_clk)
    else $error("CPU clock ran during wake delay");
  div_bound_a: assert property (
    $changed(s_reg.div_act) |-> $rose(s_reg.cpu_clk))
    else $error("divider changed mid period");

  mc_seen_c: cover property (s_reg.mc_start);
  clkout_seen_c: cover property (s_reg.drive && $rose(s_reg.pin_o));
  div_change_c: cover property ($changed(s_reg.div_act) && s_reg.div_act != 8'h00);
  wake_seen_c: cover property ($rose(s_reg.running));

endmodule : cgd_clock_gen

`default_nettype wire

// ===== verif/cgd_osc_model.sv
`default_nettype none

module cgd_osc_model (
  // Clock
  input wire logic sys_clk,
  // Oscillator levels
  output logic wdt_osc_level,
  output logic rc_osc_level,
  output logic xtal_osc_level,
  output logic ext_clk_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] lvl = 4'h0;
  logic [1:0] cnt [4] = '{default: 2'h0};
  // distinct rates per source
  // Rates stay far below the reset-pin limit, so no reset-pin option is needed
  always @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] <= (cnt[i] == 2'(i)) ? 2'h0 : cnt[i] + 2'h1;
      if (cnt[i] == 2'(i)) lvl[i] <= ~lvl[i];
    end
  end
  assign rc_osc_level = lvl[0];
  assign xtal_osc_level = lvl[1];
  assign wdt_osc_level = lvl[2];
  assign ext_clk_level = lvl[3];
endmodule : cgd_osc_model

`default_nettype wire

// ===== verif/clock_gen_divider_bench.sv
`default_nettype none
`include "cgd_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module clock_gen_divider_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic por_reset = 1'b1;
  logic [2:0] cfg_osc_sel = `CGD_SRC_RC;
  logic [5:0] factory_trim = 6'h15;
  logic rtc_uses_crystal = 1'b0;
  logic wake_request = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic port_out_data = 1'b0;
  logic port_out_oe_n = 1'b1;
  logic pin_ext = 1'b1;
  wire logic wdt, rc, xtal, ext, pin_i, pin_o, pin_oe_n, port_in, root, cpu, per, mcs, run, rcsel, lp;
  wire logic [7:0] rdata;
  wire logic [5:0] trim;
  wire logic [4:0] mon;
  int num_errors = 0;
  int n_tests = 0;

  always #50 sys_clk = ~sys_clk;
  // Released pin floats to whatever the far side drives
  assign pin_i = pin_oe_n ? pin_ext : pin_o;
  assign mon = {root, pin_o, mcs, per, cpu};

  cgd_osc_model cgd_osc_model_inst (.sys_clk(sys_clk), .wdt_osc_level(wdt), .rc_osc_level(rc),
    .xtal_osc_level(xtal), .ext_clk_level(ext));
  cgd_clock_gen cgd_clock_gen_inst (.sys_clk(sys_clk), .rst(rst), .por_reset(por_reset),
    .cfg_osc_sel(cfg_osc_sel), .factory_trim(factory_trim), .rtc_uses_crystal(rtc_uses_crystal),
    .wdt_osc_level(wdt), .rc_osc_level(rc), .xtal_osc_level(xtal), .ext_clk_level(ext),
    .wake_request(wake_request), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata), .crystal_out_clock_out_pin_i(pin_i),
    .crystal_out_clock_out_pin_o(pin_o), .crystal_out_clock_out_pin_oe_n(pin_oe_n),
    .port_out_data(port_out_data), .port_out_oe_n(port_out_oe_n), .port_in_data(port_in),
    .osc_root_clock(root), .cpu_core_clock(cpu), .periph_clock(per), .machine_cycle_start(mcs),
    .cpu_clock_running(run), .rc_osc_trim(trim), .rc_osc_clock_select(rcsel),
    .low_power_clock_select(lp));

  task automatic tally_and_finish();
    $display("tests=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    `CHK(rdata, e)
  endtask : rd_chk

  task automatic wait_run(output int c);
    c = 0;
    while (run !== 1'b1) begin
      @(negedge sys_clk);
      c++;
      if (c > 9000) begin
        num_errors++;
        tally_and_finish();
      end
    end
  endtask : wait_run

  // Hold-off window: edge count times root period, plus the fixed interval
  function automatic logic near(input int c, input int edges, input int p);
    int lo;
    lo = edges * p + `CGD_WAKE_US_MIN * `CGD_CLK_MHZ;
    return c >= lo - 8 && c <= lo + 2 * p + 8;
  endfunction : near

  task automatic do_reset(input logic [2:0] src, input logic por, output int c);
    @(posedge sys_clk);
    cfg_osc_sel <= src;
    por_reset <= por;
    factory_trim <= factory_trim + 6'h09;
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    wait_run(c);
  endtask : do_reset

  task automatic period(input int k, output int p);
    logic prev;
    prev = 1'b1;
    p = -1;
    for (int n = 0; n < 5000; n++) begin
      @(negedge sys_clk);
      if (p >= 0) p++;
      if (prev === 1'b0 && mon[k] === 1'b1) begin
        if (p > 0) return;
        p = 0;
      end
      prev = mon[k];
    end
    num_errors++;
    tally_and_finish();
  endtask : period

  task automatic sources();
    logic [2:0] src [6] = '{`CGD_SRC_RC, `CGD_SRC_WDT, `CGD_SRC_EXT, `CGD_SRC_XTAL_LOW, `CGD_SRC_XTAL_MED,
      `CGD_SRC_XTAL_HIGH};
    int pt [6] = '{2, 6, 8, 4, 4, 4};
    int c, p;
    for (int i = 0; i < 6; i++) begin
      do_reset(src[i], 1'b1, c);
      `CHK(near(c, i < 3 ? 224 : 992, pt[i]), 1'b1)
      `CHK(trim, factory_trim)
      period(4, p);
      `CHK(p, pt[i])
      rd_chk(`CGD_ADDR_STAT, {1'b1, i < 3, 1'b0, 2'b00, src[i]});
      if (i >= 3) begin
        wr(`CGD_ADDR_TRIM, 8'h40);
        repeat (3) @(negedge sys_clk);
        `CHK(pin_oe_n, 1'b1)
      end
    end
  endtask : sources

  task automatic divider();
    logic [7:0] nt [4] = '{8'h00, 8'h01, 8'h03, 8'hff};
    int c, p, e;
    do_reset(`CGD_SRC_RC, 1'b1, c);
    rd_chk(`CGD_ADDR_DIV, `CGD_DIV_RST);
    rd_chk(`CGD_ADDR_AUX1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(`CGD_ADDR_DIV, nt[i]);
      period(0, p);
      e = (nt[i] == 8'h00) ? 2 : 4 * int'(nt[i]);
      period(0, p);
      `CHK(p, e)
      period(1, p);
      `CHK(p, 2 * e)
      period(2, p);
      `CHK(p, 2 * e)
      `CHK(run, 1'b1)
    end
  endtask : divider

  task automatic clock_out();
    int p;
    wr(`CGD_ADDR_DIV, 8'h01);
    wr(`CGD_ADDR_TRIM, 8'h4a);
    repeat (3) @(negedge sys_clk);
    `CHK(pin_oe_n, 1'b0)
    rd_chk(`CGD_ADDR_STAT, 8'he3);
    period(3, p);
    `CHK(p, 8)
    @(posedge sys_clk);
    rtc_uses_crystal <= 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK(pin_oe_n, 1'b1)
    @(posedge sys_clk);
    rtc_uses_crystal <= 1'b0;
    port_out_oe_n <= 1'b0;
    port_out_data <= 1'b1;
    wr(`CGD_ADDR_TRIM, 8'h0a);
    repeat (3) @(negedge sys_clk);
    `CHK({pin_oe_n, pin_o}, 2'b01)
    @(posedge sys_clk);
    port_out_oe_n <= 1'b1;
    pin_ext <= 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK(port_in, 1'b0)
    `CHK(trim, 6'h0a)
  endtask : clock_out

  task automatic warm_reset();
    int c;
    wr(`CGD_ADDR_TRIM, 8'h8a);
    rd_chk(`CGD_ADDR_TRIM, 8'h8a);
    wr(`CGD_ADDR_AUX1, 8'h80);
    rd_chk(`CGD_ADDR_AUX1, 8'h80);
    wr(`CGD_ADDR_STAT, 8'h00);
    rd_chk(`CGD_ADDR_STAT, 8'hc3);
    rd_chk(8'h40, 8'h00);
    do_reset(`CGD_SRC_RC, 1'b0, c);
    `CHK(trim, 6'h0a)
    `CHK(rcsel, 1'b1)
    `CHK(lp, 1'b0)
    @(posedge sys_clk);
    wake_request <= 1'b1;
    @(posedge sys_clk);
    wake_request <= 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK(run, 1'b0)
    wait_run(c);
    `CHK(near(c + 3, 224, 2), 1'b1)
  endtask : warm_reset

  initial begin
    sources();
    divider();
    clock_out();
    warm_reset();
    tally_and_finish();
  end
endmodule : clock_gen_divider_bench

`default_nettype wire
